// file: core/tcse_pkg.sv
/*
  constants shared by the timer end, the port/event end and the link between them.
  assumes byte-wide register access over the link and one 100 MHz clock.
*/
package tcse_pkg;
   // register offsets
   localparam logic [5:0] OFS_CONTROL_A     = 6'h00;
   localparam logic [5:0] OFS_CONTROL_B     = 6'h01;
   localparam logic [5:0] OFS_CONTROL_D     = 6'h03;
   localparam logic [5:0] OFS_CONTROL_E_CLR = 6'h04;
   localparam logic [5:0] OFS_CONTROL_E_SET = 6'h05;
   localparam logic [5:0] OFS_BUFVALID_CLR  = 6'h06;
   localparam logic [5:0] OFS_BUFVALID_SET  = 6'h07;
   localparam logic [5:0] OFS_EVENT_CONTROL = 6'h09;
   localparam logic [5:0] OFS_INT_ENABLE    = 6'h0A;
   localparam logic [5:0] OFS_INT_FLAG      = 6'h0B;
   localparam logic [5:0] OFS_TEMP          = 6'h0F;
   localparam logic [5:0] OFS_COUNT         = 6'h20;
   localparam logic [5:0] OFS_PERIOD        = 6'h26;
   localparam logic [5:0] OFS_COMPARE0      = 6'h28;
   localparam logic [5:0] OFS_PERIOD_BUF    = 6'h36;
   localparam logic [5:0] OFS_COMPARE0_BUF  = 6'h38;
   // 16-bit register slots
   localparam int         W_COUNT = 0;
   localparam int         W_PER   = 1;
   localparam int         W_CMPV  = 2;
   localparam int         W_PBUF  = 5;
   localparam int         W_CBUF  = 6;
   localparam int         W_NUM   = 9;
   localparam logic [3:0] W_NONE  = 4'hF;
   // field positions
   localparam int A_ENABLE   = 0;
   localparam int A_PRESC    = 1;
   localparam int B_CMPEN    = 4;
   localparam int E_DIR      = 0;
   localparam int E_LOCK     = 1;
   localparam int E_CMD      = 2;
   localparam int EV_ENABLE  = 0;
   localparam int EV_ACT     = 1;
   localparam int F_WRAP     = 0;
   localparam int F_HIGH_UNF = 1;
   localparam int F_CMP      = 4;
   // codes
   localparam logic [1:0] CMD_UPDATE   = 2'h1;
   localparam logic [1:0] CMD_RESTART  = 2'h2;
   localparam logic [1:0] CMD_RESET    = 2'h3;
   localparam logic [2:0] EVENT_ACTION_SELECT_RISE   = 3'h0;
   localparam logic [2:0] EVENT_ACTION_SELECT_ANY    = 3'h1;
   localparam logic [2:0] EVENT_ACTION_SELECT_HIGH   = 3'h2;
   localparam logic [2:0] EVENT_ACTION_SELECT_UPDOWN = 3'h3;
   localparam logic [2:0] WAVE_NONE    = 3'h0;
   // host wishbone map (byte addresses)
   localparam logic [7:0] HOFS_ACCESS = 8'h00;
   localparam logic [7:0] HOFS_RDATA  = 8'h04;
   localparam logic [7:0] HOFS_PORT   = 8'h08;
   localparam logic [7:0] HOFS_EVSTAT = 8'h0C;
   localparam int         H_ACC_READ  = 16;
   localparam int         H_ACC_ADDR  = 8;
   localparam int         H_PORT_DIR  = 8;
   localparam int         H_PORT_INV  = 16;
   localparam int         H_EV_IRQ    = 8;
   localparam logic [31:0] RESET_WORD = 32'h0000_0000;
endpackage

// file: core/tcse_link_if.sv
/*
  link between the timer end and the port/event end.
  assumes both ends run on core_clk; no clocking block.
*/
`timescale 1ns/100ps
interface tcse_link_if;
   logic       reg_sel;
   logic       reg_we;
   logic [5:0] reg_addr;
   logic [7:0] reg_wdata;
   logic [7:0] reg_rdata;
   logic [5:0] pin_inv;
   logic       ev_in;
   logic [5:0] wave_pin;
   logic [5:0] wave_ovr;
   logic       ev_wrap;
   logic       ev_high_unf;
   logic [2:0] ev_cmp;
   modport dev  (input reg_sel, reg_we, reg_addr, reg_wdata, pin_inv, ev_in,
                 output reg_rdata, wave_pin, wave_ovr, ev_wrap, ev_high_unf, ev_cmp);
   modport host (output reg_sel, reg_we, reg_addr, reg_wdata, pin_inv, ev_in,
                 input reg_rdata, wave_pin, wave_ovr, ev_wrap, ev_high_unf, ev_cmp);
endinterface

// file: core/tcse_prescale.sv
/*
  prescaler: one-cycle count enable at core_clk divided by 1..1024.
  assumes run low holds the divider at zero.
*/
`timescale 1ns/100ps
module tcse_prescale (
   // clock and reset
   input  wire logic       core_clk,
   input  wire logic       sys_rst,
   // control
   input  wire logic       run,
   input  wire logic [2:0] presc_sel,
   // enable out
   output logic            tick
);
   import tcse_pkg::*;
   logic [9:0] div_ff, nxt_div;
   logic       tick_ff, nxt_tick;
   logic [9:0] mask;

   always_comb begin
      case (presc_sel)
         3'h0:    mask = 10'h000;
         3'h1:    mask = 10'h001;
         3'h2:    mask = 10'h003;
         3'h3:    mask = 10'h007;
         3'h4:    mask = 10'h00F;
         3'h5:    mask = 10'h03F;
         3'h6:    mask = 10'h0FF;
         default: mask = 10'h3FF;
      endcase
      nxt_div  = run ? div_ff + 10'h001 : 10'h000;
      nxt_tick = run && ((div_ff & mask) == mask);
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         div_ff  <= 10'h000;
         tick_ff <= 1'b0;
      end else begin
         div_ff  <= nxt_div;
         tick_ff <= nxt_tick;
      end
   end

   assign tick = tick_ff;
endmodule

// file: core/tcse_timer.sv
/*
  timer end: 16-bit counter with three compare channels, split mode,
  commands, event in/out and pin override values.
  assumes the port end sends byte register accesses and a synchronised event level.
*/
`timescale 1ns/100ps
module tcse_timer (
   // clock and reset
   input  wire logic core_clk,
   input  wire logic sys_rst,
   // link to port and event logic
   tcse_link_if.dev  link,
   // interrupt request
   output logic      irq_o
);
   import tcse_pkg::*;

   logic [3:0]  ctla_ff, nxt_ctla;
   logic [6:0]  ctlb_ff, nxt_ctlb;
   logic        split_ff, nxt_split;
   logic [1:0]  ctle_ff, nxt_ctle;
   logic [3:0]  bv_ff, nxt_bv;
   logic [3:0]  evc_ff, nxt_evc;
   logic [6:0]  ien_ff, nxt_ien;
   logic [6:0]  flag_ff, nxt_flag;
   logic [7:0]  temp_ff, nxt_temp;
   logic [7:0]  rdata_ff, nxt_rdata;
   logic [15:0] w_ff [W_NUM];
   logic [15:0] nxt_w [W_NUM];
   logic [5:0]  wave_ff, nxt_wave;
   logic [5:0]  pin_ff, nxt_pin;
   logic [5:0]  ovr_ff, nxt_ovr;
   logic [4:0]  evo_ff, nxt_evo;
   logic        ev_now_ff, ev_old_ff;
   logic        irq_ff, nxt_irq;
   logic        tick;

   tcse_prescale u_presc (
      .core_clk  (core_clk),
      .sys_rst   (sys_rst),
      .run       (ctla_ff[A_ENABLE]),
      .presc_sel (ctla_ff[A_PRESC +: 3]),
      .tick      (tick)
   );

   function automatic logic [3:0] word_slot(input logic [5:0] a);
      case (a[5:1])
         OFS_COUNT[5:1]:               word_slot = 4'(W_COUNT);
         OFS_PERIOD[5:1]:              word_slot = 4'(W_PER);
         OFS_COMPARE0[5:1]:            word_slot = 4'(W_CMPV);
         OFS_COMPARE0[5:1] + 5'h01:    word_slot = 4'(W_CMPV + 1);
         OFS_COMPARE0[5:1] + 5'h02:    word_slot = 4'(W_CMPV + 2);
         OFS_PERIOD_BUF[5:1]:          word_slot = 4'(W_PBUF);
         OFS_COMPARE0_BUF[5:1]:        word_slot = 4'(W_CBUF);
         OFS_COMPARE0_BUF[5:1] + 5'h01: word_slot = 4'(W_CBUF + 1);
         OFS_COMPARE0_BUF[5:1] + 5'h02: word_slot = 4'(W_CBUF + 2);
         default:                      word_slot = W_NONE;
      endcase
   endfunction

   always_comb begin
      logic [6:0] set_f;
      logic [6:0] clr_f;
      logic       step;
      logic       down;
      logic       wrap;
      logic       upd;
      logic       wen;
      logic       ren;
      logic [1:0] cmd;
      logic [3:0] slot;
      set_f = 7'h00;
      clr_f = 7'h00;
      wrap  = 1'b0;
      wen   = link.reg_sel & link.reg_we;
      ren   = link.reg_sel & ~link.reg_we;
      slot  = word_slot(link.reg_addr);
      cmd   = (wen && link.reg_addr == OFS_CONTROL_E_SET) ? link.reg_wdata[E_CMD +: 2] : 2'h0;
      upd   = (cmd == CMD_UPDATE);
      nxt_ctla  = ctla_ff;
      nxt_ctlb  = ctlb_ff;
      nxt_split = split_ff;
      nxt_ctle  = ctle_ff;
      nxt_bv    = bv_ff;
      nxt_evc   = evc_ff;
      nxt_ien   = ien_ff;
      nxt_temp  = temp_ff;
      nxt_rdata = rdata_ff;
      nxt_wave  = wave_ff;
      nxt_w     = w_ff;
      // count source; edge actions replace the prescaler
      step = tick;
      down = ctle_ff[E_DIR];
      if (evc_ff[EV_ENABLE] && !split_ff) begin
         case (evc_ff[EV_ACT +: 3])
            EVENT_ACTION_SELECT_RISE:   step = ev_now_ff & ~ev_old_ff;
            EVENT_ACTION_SELECT_ANY:    step = ev_now_ff ^ ev_old_ff;
            EVENT_ACTION_SELECT_HIGH:   step = tick & ev_now_ff;
            EVENT_ACTION_SELECT_UPDOWN: begin
               down = ev_now_ff;
               nxt_ctle[E_DIR] = ev_now_ff;
            end
            default:      step = tick;
         endcase
      end
      step = step & ctla_ff[A_ENABLE];
      if (step && split_ff) begin
         for (int h = 0; h < 2; h++) begin
            for (int c = 0; c < 3; c++) begin
               if (w_ff[W_COUNT][h*8 +: 8] == w_ff[W_CMPV + c][h*8 +: 8]) begin
                  nxt_wave[h*3 + c] = 1'b1;
                  if (h == 0) set_f[F_CMP + c] = 1'b1;
               end
            end
            // bottom clear after the match keeps the top duty below one
            if (w_ff[W_COUNT][h*8 +: 8] == 8'h00) begin
               nxt_w[W_COUNT][h*8 +: 8] = w_ff[W_PER][h*8 +: 8];
               nxt_wave[h*3 +: 3]       = 3'b000;
               set_f[h]                 = 1'b1;
            end else begin
               nxt_w[W_COUNT][h*8 +: 8] = w_ff[W_COUNT][h*8 +: 8] - 8'h01;
            end
         end
      end else if (step) begin
         wrap = down ? (w_ff[W_COUNT] == 16'h0000) : (w_ff[W_COUNT] == w_ff[W_PER]);
         if (down) nxt_w[W_COUNT] = wrap ? w_ff[W_PER] : w_ff[W_COUNT] - 16'h0001;
         else nxt_w[W_COUNT] = wrap ? 16'h0000 : w_ff[W_COUNT] + 16'h0001;
         if (wrap) begin
            set_f[F_WRAP] = 1'b1;
            nxt_wave[2:0] = 3'b111;
            upd           = upd | ~ctle_ff[E_LOCK];
         end
         for (int c = 0; c < 3; c++) begin
            if (w_ff[W_COUNT] == w_ff[W_CMPV + c]) set_f[F_CMP + c] = 1'b1;
            if (nxt_w[W_COUNT] == w_ff[W_CMPV + c]) nxt_wave[c] = 1'b0;
         end
      end
      if (upd && !split_ff) begin
         if (bv_ff[0]) nxt_w[W_PER] = w_ff[W_PBUF];
         for (int c = 0; c < 3; c++) begin
            if (bv_ff[c + 1]) nxt_w[W_CMPV + c] = w_ff[W_CBUF + c];
         end
         nxt_bv = 4'h0;
      end
      if (wen) begin
         case (link.reg_addr)
            OFS_CONTROL_A:     nxt_ctla  = link.reg_wdata[3:0];
            OFS_CONTROL_B:     nxt_ctlb  = link.reg_wdata[6:0];
            OFS_CONTROL_D:     nxt_split = link.reg_wdata[0];
            OFS_CONTROL_E_CLR: nxt_ctle  = ctle_ff & ~link.reg_wdata[1:0];
            OFS_CONTROL_E_SET: nxt_ctle  = ctle_ff | link.reg_wdata[1:0];
            OFS_BUFVALID_CLR:  nxt_bv    = bv_ff & ~link.reg_wdata[3:0];
            OFS_BUFVALID_SET:  nxt_bv    = bv_ff | link.reg_wdata[3:0];
            OFS_EVENT_CONTROL: nxt_evc   = link.reg_wdata[3:0];
            OFS_INT_ENABLE:    nxt_ien   = link.reg_wdata[6:0];
            OFS_INT_FLAG:      clr_f     = link.reg_wdata[6:0];
            OFS_TEMP:          nxt_temp  = link.reg_wdata;
            default: begin
               if (slot != W_NONE) begin
                  if (split_ff) begin
                     nxt_w[slot][link.reg_addr[0]*8 +: 8] = link.reg_wdata;
                  end else if (!link.reg_addr[0]) begin
                     nxt_temp = link.reg_wdata;
                  end else begin
                     nxt_w[slot] = {link.reg_wdata, temp_ff};
                  end
                  if (slot >= 4'(W_PBUF) && (split_ff || link.reg_addr[0])) begin
                     nxt_bv[2'(slot - 4'(W_PBUF))] = 1'b1;
                  end
               end
            end
         endcase
      end
      if (cmd == CMD_RESTART) begin
         nxt_w[W_COUNT]  = 16'h0000;
         nxt_ctle[E_DIR] = 1'b0;
         nxt_wave        = 6'h00;
      end
      // hardware set wins over a same-cycle clear
      nxt_flag = (flag_ff & ~clr_f) | set_f;
      nxt_evo  = {set_f[F_CMP +: 3], set_f[F_HIGH_UNF], set_f[F_WRAP]};
      if (cmd == CMD_RESET && !ctla_ff[A_ENABLE]) begin
         nxt_ctla  = 4'h0;
         nxt_ctlb  = 7'h00;
         nxt_split = 1'b0;
         nxt_ctle  = 2'h0;
         nxt_bv    = 4'h0;
         nxt_evc   = 4'h0;
         nxt_ien   = 7'h00;
         nxt_flag  = 7'h00;
         nxt_temp  = 8'h00;
         nxt_wave  = 6'h00;
         for (int i = 0; i < W_NUM; i++) nxt_w[i] = 16'h0000;
      end
      if (ren) begin
         case (link.reg_addr)
            OFS_CONTROL_A:     nxt_rdata = {4'h0, ctla_ff};
            OFS_CONTROL_B:     nxt_rdata = {1'b0, ctlb_ff};
            OFS_CONTROL_D:     nxt_rdata = {7'h00, split_ff};
            OFS_CONTROL_E_CLR,
            OFS_CONTROL_E_SET: nxt_rdata = {6'h00, ctle_ff};
            OFS_BUFVALID_CLR,
            OFS_BUFVALID_SET:  nxt_rdata = {4'h0, bv_ff};
            OFS_EVENT_CONTROL: nxt_rdata = {4'h0, evc_ff};
            OFS_INT_ENABLE:    nxt_rdata = {1'b0, ien_ff};
            OFS_INT_FLAG:      nxt_rdata = {1'b0, flag_ff};
            OFS_TEMP:          nxt_rdata = temp_ff;
            default: begin
               if (slot == W_NONE) begin
                  nxt_rdata = 8'h00;
               end else if (split_ff) begin
                  nxt_rdata = w_ff[slot][link.reg_addr[0]*8 +: 8];
               end else if (!link.reg_addr[0]) begin
                  nxt_rdata = w_ff[slot][7:0];
                  nxt_temp  = w_ff[slot][15:8];
               end else begin
                  nxt_rdata = temp_ff;
               end
            end
         endcase
      end
      // override: split drives six pins, normal three with a wave mode
      nxt_ovr = split_ff ? {ctlb_ff[B_CMPEN +: 3], ctlb_ff[2:0]}
                         : {3'b000, ctlb_ff[B_CMPEN +: 3] & {3{ctlb_ff[2:0] != WAVE_NONE}}};
      nxt_pin = wave_ff ^ link.pin_inv;
      nxt_irq = |(flag_ff & ien_ff);
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         ctla_ff   <= 4'h0;
         ctlb_ff   <= 7'h00;
         split_ff  <= 1'b0;
         ctle_ff   <= 2'h0;
         bv_ff     <= 4'h0;
         evc_ff    <= 4'h0;
         ien_ff    <= 7'h00;
         flag_ff   <= 7'h00;
         temp_ff   <= 8'h00;
         rdata_ff  <= 8'h00;
         wave_ff   <= 6'h00;
         pin_ff    <= 6'h00;
         ovr_ff    <= 6'h00;
         evo_ff    <= 5'h00;
         ev_now_ff <= 1'b0;
         ev_old_ff <= 1'b0;
         irq_ff    <= 1'b0;
         for (int i = 0; i < W_NUM; i++) w_ff[i] <= 16'h0000;
      end else begin
         ctla_ff   <= nxt_ctla;
         ctlb_ff   <= nxt_ctlb;
         split_ff  <= nxt_split;
         ctle_ff   <= nxt_ctle;
         bv_ff     <= nxt_bv;
         evc_ff    <= nxt_evc;
         ien_ff    <= nxt_ien;
         flag_ff   <= nxt_flag;
         temp_ff   <= nxt_temp;
         rdata_ff  <= nxt_rdata;
         wave_ff   <= nxt_wave;
         pin_ff    <= nxt_pin;
         ovr_ff    <= nxt_ovr;
         evo_ff    <= nxt_evo;
         ev_now_ff <= link.ev_in;
         ev_old_ff <= ev_now_ff;
         irq_ff    <= nxt_irq;
         w_ff      <= nxt_w;
      end
   end

   assign link.reg_rdata   = rdata_ff;
   assign link.wave_pin    = pin_ff;
   assign link.wave_ovr    = ovr_ff;
   assign link.ev_wrap     = evo_ff[0];
   assign link.ev_high_unf = evo_ff[1];
   assign link.ev_cmp      = evo_ff[4:2];
   assign irq_o            = irq_ff;
endmodule

// file: core/tcse_host.sv
/*
  port and event end: wishbone slave for software, drives the timer link,
  merges waveform override into the pins, latches timer events.
  assumes a classic single-cycle wishbone master on core_clk.
*/
`timescale 1ns/100ps
module tcse_host (
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        sys_rst,
   // wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   // pins
   input  wire logic        ev_pin_i,
   output logic [5:0]       pin_o,
   output logic [5:0]       pin_oe,
   // timer link
   tcse_link_if.host        link
);
   import tcse_pkg::*;

   typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_LINK = 2'b01, ST_ACK = 2'b11} tcse_hst_t;

   tcse_hst_t   st_ff, nxt_st;
   logic [31:0] port_ff, nxt_port;
   logic [4:0]  evs_ff, nxt_evs;
   logic [7:0]  rd_ff, nxt_rd;
   logic [31:0] dat_ff, nxt_dat;
   logic        ack_ff, nxt_ack;
   logic        sel_ff, nxt_sel;
   logic        we_ff, nxt_we;
   logic [5:0]  adr_ff, nxt_adr;
   logic [7:0]  wd_ff, nxt_wd;
   logic [5:0]  pin_ff, nxt_pin;
   logic [1:0]  evsync_ff;

   function automatic logic [31:0] lanes(input logic [3:0] s);
      lanes = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
   endfunction

   always_comb begin
      logic [4:0]  hits;
      logic        req;
      hits     = {link.ev_cmp, link.ev_high_unf, link.ev_wrap};
      req      = wb_cyc_i & wb_stb_i;
      nxt_st   = st_ff;
      nxt_port = port_ff;
      nxt_evs  = evs_ff | hits;
      nxt_rd   = rd_ff;
      nxt_dat  = dat_ff;
      nxt_ack  = 1'b0;
      nxt_sel  = 1'b0;
      nxt_we   = we_ff;
      nxt_adr  = adr_ff;
      nxt_wd   = wd_ff;
      case (st_ff)
         ST_IDLE: begin
            if (req) begin
               nxt_dat = RESET_WORD;
               if (wb_adr_i == HOFS_ACCESS && wb_we_i) begin
                  nxt_sel = 1'b1;
                  nxt_we  = ~wb_dat_i[H_ACC_READ];
                  nxt_adr = wb_dat_i[H_ACC_ADDR +: 6];
                  nxt_wd  = wb_dat_i[7:0];
                  nxt_st  = ST_LINK;
               end else begin
                  nxt_ack = 1'b1;
                  nxt_st  = ST_ACK;
                  case (wb_adr_i)
                     HOFS_RDATA:  nxt_dat = {24'h00_0000, rd_ff};
                     HOFS_PORT: begin
                        nxt_dat = port_ff;
                        if (wb_we_i) nxt_port = (port_ff & ~lanes(wb_sel_i)) | (wb_dat_i & lanes(wb_sel_i));
                     end
                     HOFS_EVSTAT: begin
                        nxt_dat = {27'h000_0000, evs_ff};
                        // set wins over a same-cycle clear
                        if (wb_we_i && wb_sel_i[0]) nxt_evs = (evs_ff & ~wb_dat_i[4:0]) | hits;
                     end
                     default:     nxt_dat = RESET_WORD;
                  endcase
               end
            end
         end
         ST_LINK: begin
            nxt_ack = 1'b1;
            nxt_st  = ST_ACK;
         end
         // timer read data lands a cycle after the strobe and stands until the next read
         ST_ACK: begin
            if (!we_ff) nxt_rd = link.reg_rdata;
            nxt_st = ST_IDLE;
         end
         default: nxt_st = ST_IDLE;
      endcase
      for (int i = 0; i < 6; i++) begin
         nxt_pin[i] = link.wave_ovr[i] ? link.wave_pin[i] : port_ff[i];
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         st_ff     <= ST_IDLE;
         port_ff   <= RESET_WORD;
         evs_ff    <= 5'h00;
         rd_ff     <= 8'h00;
         dat_ff    <= RESET_WORD;
         ack_ff    <= 1'b0;
         sel_ff    <= 1'b0;
         we_ff     <= 1'b0;
         adr_ff    <= 6'h00;
         wd_ff     <= 8'h00;
         pin_ff    <= 6'h00;
         evsync_ff <= 2'b00;
      end else begin
         st_ff     <= nxt_st;
         port_ff   <= nxt_port;
         evs_ff    <= nxt_evs;
         rd_ff     <= nxt_rd;
         dat_ff    <= nxt_dat;
         ack_ff    <= nxt_ack;
         sel_ff    <= nxt_sel;
         we_ff     <= nxt_we;
         adr_ff    <= nxt_adr;
         wd_ff     <= nxt_wd;
         pin_ff    <= nxt_pin;
         evsync_ff <= {evsync_ff[0], ev_pin_i};
      end
   end

   assign wb_dat_o       = dat_ff;
   assign wb_ack_o       = ack_ff;
   assign pin_o          = pin_ff;
   assign pin_oe         = port_ff[H_PORT_DIR +: 6];
   assign link.reg_sel   = sel_ff;
   assign link.reg_we    = we_ff;
   assign link.reg_addr  = adr_ff;
   assign link.reg_wdata = wd_ff;
   assign link.pin_inv   = port_ff[H_PORT_INV +: 6];
   assign link.ev_in     = evsync_ff[1];
endmodule

// file: verif/tcse_asserts.sv
/* link checks beside the interface; assumes one clock and only software writes change shadows */
`timescale 1ns/100ps
module tcse_asserts import tcse_pkg::*; (
   // clock and reset
   input logic       core_clk,
   input logic       sys_rst,
   // link
   input logic       reg_sel,
   input logic       reg_we,
   input logic [5:0] reg_addr,
   input logic [7:0] reg_wdata,
   input logic [7:0] reg_rdata,
   input logic [5:0] pin_inv,
   input logic [5:0] wave_pin,
   input logic [5:0] wave_ovr,
   input logic       ev_wrap,
   input logic       ev_high_unf,
   input logic [2:0] ev_cmp
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   logic [7:0] ctrl_b_ff;
   logic       split_ff;
   logic       run_ff;
   logic       wr;
   assign wr = reg_sel && reg_we;
   // reset commands are not tracked: stale shadows only weaken the checks
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         ctrl_b_ff <= 8'h00;
         split_ff  <= 1'b0;
         run_ff    <= 1'b0;
      end else if (wr) begin
         if (reg_addr == OFS_CONTROL_B) ctrl_b_ff <= reg_wdata;
         if (reg_addr == OFS_CONTROL_D) split_ff <= reg_wdata[0];
         if (reg_addr == OFS_CONTROL_A) run_ff <= reg_wdata[A_ENABLE];
      end
   end
   a_sel_spaced: assert property (reg_sel |=> !reg_sel [*3]) else $error("link strobe too close");
   a_rdata_hold: assert property (!reg_sel |=> $stable(reg_rdata)) else $error("read data moved");
   a_write_quiet: assert property (wr |=> $stable(reg_rdata)) else $error("write moved read data");
   a_unmapped_zero: assert property (reg_sel && !reg_we && reg_addr == 6'h08 |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_no_ovr_idle: assert property (ctrl_b_ff == 8'h00 && $past(ctrl_b_ff) == 8'h00 |-> wave_ovr == 6'h00)
      else $error("override without enable");
   a_high_byte_underflow_split: assert property (ev_high_unf |-> split_ff) else $error("high underflow outside split");
   a_quiet_off: assert property (!run_ff && !$past(run_ff) && !$past(run_ff, 2) |->
      !ev_wrap && !ev_high_unf && ev_cmp == 3'h0) else $error("event while stopped");
   a_restart_clear: assert property (wr && split_ff && reg_addr == OFS_CONTROL_E_SET &&
      reg_wdata[3:2] == CMD_RESTART |-> ##[1:3] (wave_pin[2:0] ^ pin_inv[2:0]) == 3'h0)
      else $error("restart left outputs set");
endmodule

// file: verif/timer_commands_split_events_test.sv
/* bench for both ends joined by the link; assumes the wishbone map of the package */
`timescale 1ns/100ps
module timer_commands_split_events_test;
   import tcse_pkg::*;
   logic        core_clk = 1'b0;
   logic        sys_rst  = 1'b1;
   logic        wb_cyc   = 1'b0;
   logic        wb_stb   = 1'b0;
   logic        wb_we    = 1'b0;
   logic        ev_pin   = 1'b0;
   logic [7:0]  wb_adr   = 8'h00;
   logic [31:0] wb_dat   = 32'h0000_0000;
   logic [31:0] rng      = 32'hb0d6_b19d;
   logic [31:0] wb_rd;
   logic        wb_ack;
   logic        irq;
   logic [5:0]  pin_o;
   logic [5:0]  pin_oe;
   logic [31:0] exp_q[$];
   int          bad_count = 0;
   int          comparisons = 0;
   tcse_link_if link ();
   tcse_timer u_tcse_timer (.core_clk(core_clk), .sys_rst(sys_rst), .link(link), .irq_o(irq));
   tcse_host u_tcse_host (.core_clk(core_clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
      .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_dat), .wb_dat_o(wb_rd),
      .wb_ack_o(wb_ack), .ev_pin_i(ev_pin), .pin_o(pin_o), .pin_oe(pin_oe), .link(link));
   tcse_asserts u_tcse_asserts (.core_clk(core_clk), .sys_rst(sys_rst), .reg_sel(link.reg_sel),
      .reg_we(link.reg_we), .reg_addr(link.reg_addr), .reg_wdata(link.reg_wdata), .reg_rdata(link.reg_rdata),
      .pin_inv(link.pin_inv), .wave_pin(link.wave_pin), .wave_ovr(link.wave_ovr), .ev_wrap(link.ev_wrap),
      .ev_high_unf(link.ev_high_unf), .ev_cmp(link.ev_cmp));
   always #5 core_clk = ~core_clk;
   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] r;
      r = v ^ (v << 13);
      r = r ^ (r >> 17);
      return r ^ (r << 5);
   endfunction
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
      comparisons++;
      if (seen !== want) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", what, want, seen);
      end
   endtask
   task automatic give_verdict();
      $display("comparisons %0d bad_count %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // classic cycle: hold until ack is sampled, then one idle cycle
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we  <= we;
      wb_adr <= adr;
      wb_dat <= dat;
      @(posedge core_clk);
      while (wb_ack !== 1'b1) @(posedge core_clk);
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic tw(input logic [5:0] a, input logic [7:0] d);
      wb(1'b1, HOFS_ACCESS, {18'h0_0000, a, d});
   endtask
   task automatic tr(input logic [5:0] a, input logic [7:0] e);
      wb(1'b1, HOFS_ACCESS, {15'h0000, 1'b1, 2'b00, a, 8'h00});
      exp_q.push_back({24'h00_0000, e});
      wb(1'b0, HOFS_RDATA, 32'h0000_0000);
   endtask
   always @(posedge core_clk) if (wb_ack === 1'b1 && wb_we === 1'b0) check("read", wb_rd, exp_q.pop_front());
   // 60 cycles span whole periods of both byte counters, so counts are phase free
   task automatic win(input int e0, input int e3, input int ew, input int eh, input int ec);
      int c[5];
      c = '{0, 0, 0, 0, 0};
      repeat (4) @(posedge core_clk);
      for (int i = 0; i < 60; i++) begin
         @(posedge core_clk);
         rng = xs(rng);
         if (i % 4 == 0) ev_pin <= rng[0];
         c[0] += (pin_o[0] === 1'b1);
         c[1] += (pin_o[3] === 1'b1);
         c[2] += (link.ev_wrap === 1'b1);
         c[3] += (link.ev_high_unf === 1'b1);
         c[4] += (link.ev_cmp[0] === 1'b1);
      end
      check("low duty", c[0], e0);
      check("high duty", c[1], e3);
      check("low underflows", c[2], ew);
      check("high underflows", c[3], eh);
      check("compare events", c[4], ec);
   endtask
   initial begin
      repeat (5) @(posedge core_clk);
      sys_rst <= 1'b0;
      @(posedge core_clk);
      tr(OFS_COUNT, 8'h00);
      tr(6'h08, 8'h00);
      exp_q.push_back(32'h0000_0000);
      wb(1'b0, 8'h10, 32'h0000_0000);
      wb(1'b1, HOFS_PORT, 32'h0000_3f2a);
      repeat (3) @(posedge core_clk);
      check("pin out", pin_o, 6'h2a);
      check("pin dir", pin_oe, 6'h3f);
      tw(OFS_CONTROL_D, 8'h01);
      tw(OFS_PERIOD, 8'h03);
      tw(OFS_PERIOD + 6'h01, 8'h05);
      tw(OFS_COMPARE0, 8'h03);
      tw(OFS_COMPARE0 + 6'h01, 8'h05);
      tw(OFS_CONTROL_B, 8'h11);
      tw(OFS_INT_ENABLE, 8'h02);
      tw(OFS_EVENT_CONTROL, {4'h0, EVENT_ACTION_SELECT_HIGH, 1'b1});
      tw(OFS_CONTROL_A, 8'h01);
      win(45, 50, 15, 10, 15);
      check("irq", irq, 1'b1);
      exp_q.push_back(32'h0000_001f);
      wb(1'b0, HOFS_EVSTAT, 32'h0000_0000);
      wb(1'b1, HOFS_PORT, 32'h0001_3f2a);
      win(15, 50, 15, 10, 15);
      tw(OFS_CONTROL_E_SET, {4'h0, CMD_RESTART, 2'b00});
      tw(OFS_CONTROL_E_SET, {4'h0, CMD_RESET, 2'b00});
      tr(OFS_PERIOD, 8'h03);
      tw(OFS_CONTROL_A, 8'h00);
      tw(OFS_INT_FLAG, 8'h7f);
      check("irq", irq, 1'b0);
      tw(OFS_CONTROL_D, 8'h00);
      tr(OFS_PERIOD, 8'h03);
      tr(OFS_PERIOD + 6'h01, 8'h05);
      tw(OFS_CONTROL_E_SET, {4'h0, CMD_RESET, 2'b00});
      tr(OFS_PERIOD, 8'h00);
      tr(OFS_CONTROL_D, 8'h00);
      tw(OFS_PERIOD_BUF, 8'h07);
      tw(OFS_PERIOD_BUF + 6'h01, 8'h00);
      tw(OFS_CONTROL_E_SET, {4'h0, CMD_UPDATE, 2'b10});
      tr(OFS_PERIOD, 8'h07);
      ev_pin <= 1'b0;
      tw(OFS_EVENT_CONTROL, {4'h0, EVENT_ACTION_SELECT_RISE, 1'b1});
      tw(OFS_CONTROL_A, 8'h0f);
      repeat (3) begin
         ev_pin <= 1'b1;
         repeat (2) @(posedge core_clk);
         ev_pin <= 1'b0;
         repeat (2) @(posedge core_clk);
      end
      tr(OFS_COUNT, 8'h03);
      give_verdict();
   end
   initial begin
      #50000;
      bad_count++;
      give_verdict();
   end
endmodule
